// [pkg/adc_seq_pkg.sv]
// Constants shared by the conversion sequencer and its helper modules.
// Assumes a single 25 MHz system clock and an 8-bit register port.
`default_nettype none
package adc_seq_pkg;
   // Register port widths.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int RES_W = 8;
   localparam int STEP_W = 3;

   // Register offsets.
   localparam logic [3:0] CTRL_OFS = 4'h0;
   localparam logic [3:0] RESULT_OFS = 4'h1;
   localparam logic [3:0] FLAGS_OFS = 4'h2;
   localparam logic [3:0] ENABLES_OFS = 4'h3;
   localparam logic [3:0] CORE_OFS = 4'h4;

   // Field positions.
   localparam int CTRL_POWER_BIT = 0;
   localparam int CTRL_GO_BIT = 1;
   localparam int CTRL_RC_BIT = 2;
   localparam int FLAG_DONE_BIT = 0;
   localparam int CORE_GIE_BIT = 0;
   localparam int CORE_PERIPHERAL_IRQ_ENABLE_BIT = 1;

   // Reset values.
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] SAR_FIRST = 8'h80;
   localparam logic [2:0] STEP_FIRST = 3'h7;
   localparam logic [2:0] STEP_LAST = 3'h0;

   // Timing: clock, instruction cycle and conversion step times.
   localparam int CLK_PERIOD_NS = 40;
   localparam int INSTR_DIV = 4;
   localparam int SYS_STEP_NS = 320;
   localparam int RC_STEP_NS = 2000;
   localparam int SYS_STEP_CYC = (SYS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RC_STEP_CYC = (RC_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DIV_W = 8;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DELAY,
      ST_CONVERT
   } seq_state_e;

   // Wake-up sequence phases.
   typedef enum logic [1:0] {
      WK_NONE,
      WK_NEXT,
      WK_DECIDE
   } wake_phase_e;
endpackage
`default_nettype wire

// [src/tick_div.sv]
// Free-running divider that emits a one-cycle enable pulse every DIV cycles.
// Assumes a synchronous clear from logic on the same clock.
`default_nettype none
module tick_div #(
   parameter int unsigned DIV = 4,
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Control and output.
   input wire logic clear,
   output logic tick
);
   logic [W-1:0] cnt_q;
   logic last;

   // The pulse marks the last count of each period.
   assign last = (cnt_q == W'(DIV - 1));
   assign tick = last & ~clear;

   // A clear restarts the period so the first tick comes a full period later.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (clear || last) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + W'(1);
      end
   end
endmodule
`default_nettype wire

// [src/sync3.sv]
// Three-stage synchroniser for a level from outside the clock domain.
// The output follows only once the second and third stages agree.
`default_nettype none
module sync3 (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Asynchronous level in, filtered level out.
   input wire logic async_in,
   output logic level_q
);
   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds the second and nothing else.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Agreement of two settled stages rejects a single-cycle glitch.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         level_q <= 1'b0;
      end else if (s2_q == s3_q) begin
         level_q <= s3_q;
      end
   end
endmodule
`default_nettype wire

// [src/adc_conversion_sequencer.sv]
// Sequencer of an 8-bit successive-approximation converter with its
// control, result, flag and enable registers and the sleep and wake logic.
// Assumes a comparator input from the analog side and a trigger pulse and
// sleep command from logic on the same clock.
//
// The implementer's own choices: the address map and the plain strobed port.
`default_nettype none
// Overview of operation
// - The busy bit can only be raised while the converter power bit is set.
// - Writing one to the busy bit starts a conversion; it reads high meanwhile.
// - On completion busy clears, the done flag sets and the result loads.
// - The done flag sets always; the interrupt is forwarded only when enabled.
// - Clearing busy early stores the partial result, filling with the last bit.
// - Reset returns every register to its reset value and drops any conversion.
// - Only the dedicated RC clock allows conversion to continue in sleep.
// - With the RC clock, start waits one extra instruction cycle.
// - Completion in sleep with the interrupt enabled wakes the device.
// - Completion in sleep without the interrupt powers down, power bit stays.
// - Sleep with another clock aborts and powers down, power bit stays.
// - After wake the core first runs the instruction after sleep.
// - After wake it branches to service only if both global enables are set.
// - The capture/compare trigger starts a conversion and resets the counter.
module adc_conversion_sequencer (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Register port.
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata_q,
   // Analog side.
   input wire logic comp_in,
   output logic [7:0] sar_code_q,
   output logic converter_powered_q,
   // Trigger and secondary counter.
   input wire logic special_trigger,
   output logic counter_reset_q,
   // Core sleep and wake.
   input wire logic sleep_cmd,
   input wire logic other_wake,
   output logic in_sleep_q,
   output logic wake_q,
   output logic exec_next_q,
   output logic isr_branch_q,
   output logic resume_inline_q,
   // Interrupt.
   output logic irq_q
);
   adc_seq_pkg::seq_state_e state_q;
   adc_seq_pkg::seq_state_e state_d;
   adc_seq_pkg::wake_phase_e wake_q_ph;
   logic power_on_q;
   logic rc_sel_q;
   logic [7:0] result_q;
   logic [7:0] flags_q;
   logic [7:0] enables_q;
   logic [7:0] core_q;
   logic [2:0] step_q;
   logic down_q;
   logic comp_q;
   logic instr_tick;
   logic sys_tick;
   logic rc_tick;
   logic conv_tick;
   logic conv_clear;

   // Register decode.
   logic ctrl_wr;
   logic flags_wr;
   logic enables_wr;
   logic core_wr;
   logic busy;
   logic irq_en;
   logic go_wr;
   logic power_wr;
   assign ctrl_wr = wr & (addr == adc_seq_pkg::CTRL_OFS);
   assign flags_wr = wr & (addr == adc_seq_pkg::FLAGS_OFS);
   assign enables_wr = wr & (addr == adc_seq_pkg::ENABLES_OFS);
   assign core_wr = wr & (addr == adc_seq_pkg::CORE_OFS);
   assign go_wr = wdata[adc_seq_pkg::CTRL_GO_BIT];
   assign power_wr = wdata[adc_seq_pkg::CTRL_POWER_BIT];
   assign busy = (state_q != adc_seq_pkg::ST_IDLE);
   assign irq_en = enables_q[adc_seq_pkg::FLAG_DONE_BIT];

   // Start, stop and abort conditions.
   logic sw_start;
   logic hw_start;
   logic start;
   logic power_off;
   logic sleep_abort;
   logic sw_stop;
   logic kill;
   assign sw_start = ctrl_wr & go_wr & power_on_q;
   assign hw_start = special_trigger & power_on_q;
   assign start = (sw_start | hw_start) & ~busy & ~down_q;
   assign power_off = ctrl_wr & ~power_wr;
   assign sleep_abort = sleep_cmd & ~rc_sel_q & busy;
   assign sw_stop = ctrl_wr & ~go_wr & busy;
   assign kill = power_off | sleep_abort;

   // Successive approximation: resolve the trial bit, then try the next one.
   logic [7:0] step_mask;
   logic [7:0] sar_resolved;
   logic [7:0] sar_next;
   logic final_step;
   logic done_evt;
   assign step_mask = 8'h01 << step_q;
   assign sar_resolved = comp_q ? sar_code_q : (sar_code_q & ~step_mask);
   assign sar_next = sar_resolved | (step_mask >> 1);
   assign final_step = (step_q == adc_seq_pkg::STEP_LAST);
   assign done_evt = (state_q == adc_seq_pkg::ST_CONVERT) & conv_tick & final_step & ~kill & ~sw_stop;

   // Early stop keeps resolved bits and copies the last one downward.
   logic [7:0] partial;
   logic fill_bit;
   always_comb begin
      fill_bit = (step_q == adc_seq_pkg::STEP_FIRST) ? 1'b0 : sar_code_q[step_q + 3'h1];
      for (int i = 0; i < adc_seq_pkg::RES_W; i++) begin
         partial[i] = (i > int'(step_q)) ? sar_code_q[i] : fill_bit;
      end
   end
   logic partial_evt;
   assign partial_evt = sw_stop & ~kill & (state_q == adc_seq_pkg::ST_CONVERT);

   // Step clock: the RC divider keeps its own slower rate.
   assign conv_tick = rc_sel_q ? rc_tick : sys_tick;
   assign conv_clear = start | (state_q == adc_seq_pkg::ST_DELAY);

   tick_div #(.DIV(adc_seq_pkg::INSTR_DIV), .W(adc_seq_pkg::DIV_W)) u_instr_div (
      .clk(clk),
      .rst(rst),
      .clear(1'b0),
      .tick(instr_tick)
   );
   tick_div #(.DIV(adc_seq_pkg::SYS_STEP_CYC), .W(adc_seq_pkg::DIV_W)) u_sys_div (
      .clk(clk),
      .rst(rst),
      .clear(conv_clear),
      .tick(sys_tick)
   );
   tick_div #(.DIV(adc_seq_pkg::RC_STEP_CYC), .W(adc_seq_pkg::DIV_W)) u_rc_div (
      .clk(clk),
      .rst(rst),
      .clear(conv_clear),
      .tick(rc_tick)
   );
   sync3 u_comp_sync (
      .clk(clk),
      .rst(rst),
      .async_in(comp_in),
      .level_q(comp_q)
   );

   // Next state of the sequencer; kill and stop take priority over progress.
   always_comb begin
      state_d = state_q;
      case (state_q)
         adc_seq_pkg::ST_IDLE: begin
            if (start && rc_sel_q) begin
               state_d = adc_seq_pkg::ST_DELAY;
            end else if (start) begin
               state_d = adc_seq_pkg::ST_CONVERT;
            end
         end
         adc_seq_pkg::ST_DELAY: begin
            if (kill || sw_stop) begin
               state_d = adc_seq_pkg::ST_IDLE;
            end else if (instr_tick) begin
               state_d = adc_seq_pkg::ST_CONVERT;
            end
         end
         adc_seq_pkg::ST_CONVERT: begin
            if (kill || sw_stop || done_evt) begin
               state_d = adc_seq_pkg::ST_IDLE;
            end
         end
         default: begin
            state_d = adc_seq_pkg::ST_IDLE;
         end
      endcase
   end

   // Sequencer state and approximation register; reset drops any conversion.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= adc_seq_pkg::ST_IDLE;
         step_q <= adc_seq_pkg::STEP_FIRST;
         sar_code_q <= adc_seq_pkg::REG_RESET;
      end else begin
         state_q <= state_d;
         if (start) begin
            step_q <= adc_seq_pkg::STEP_FIRST;
            sar_code_q <= adc_seq_pkg::SAR_FIRST;
         end else if (state_q == adc_seq_pkg::ST_CONVERT && conv_tick && !final_step) begin
            step_q <= step_q - 3'h1;
            sar_code_q <= sar_next;
         end else if (state_q == adc_seq_pkg::ST_CONVERT && conv_tick) begin
            sar_code_q <= sar_resolved;
         end
      end
   end

   // Control bits and result register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         power_on_q <= 1'b0;
         rc_sel_q <= 1'b0;
         result_q <= adc_seq_pkg::RESULT_RESET;
      end else begin
         if (ctrl_wr) begin
            power_on_q <= power_wr;
            rc_sel_q <= wdata[adc_seq_pkg::CTRL_RC_BIT];
         end
         if (done_evt) begin
            result_q <= sar_resolved;
         end else if (partial_evt) begin
            result_q <= partial;
         end
      end
   end

   // Sticky flag, set wins over a write-one clear; enables are plain stores.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q <= adc_seq_pkg::REG_RESET;
         enables_q <= adc_seq_pkg::REG_RESET;
         core_q <= adc_seq_pkg::REG_RESET;
      end else begin
         if (done_evt) begin
            flags_q[adc_seq_pkg::FLAG_DONE_BIT] <= 1'b1;
         end else if (flags_wr && wdata[adc_seq_pkg::FLAG_DONE_BIT]) begin
            flags_q[adc_seq_pkg::FLAG_DONE_BIT] <= 1'b0;
         end
         if (enables_wr) begin
            enables_q <= {7'h00, wdata[adc_seq_pkg::FLAG_DONE_BIT]};
         end
         if (core_wr) begin
            core_q <= {6'h00, wdata[1:0]};
         end
      end
   end

   // Interrupt level and register read data.
   logic [7:0] rd_mux;
   assign rd_mux = (addr == adc_seq_pkg::CTRL_OFS) ? {5'h00, rc_sel_q, busy, power_on_q} :
                   (addr == adc_seq_pkg::RESULT_OFS) ? result_q :
                   (addr == adc_seq_pkg::FLAGS_OFS) ? flags_q :
                   (addr == adc_seq_pkg::ENABLES_OFS) ? enables_q :
                   (addr == adc_seq_pkg::CORE_OFS) ? core_q : 8'h00;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         irq_q <= |(flags_q & enables_q);
         rdata_q <= rd ? rd_mux : 8'h00;
      end
   end

   // Sleep and converter power. Powering down leaves the power bit as read.
   logic wake_evt;
   assign wake_evt = in_sleep_q & ((done_evt & irq_en) | other_wake);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         in_sleep_q <= 1'b0;
         down_q <= 1'b0;
         converter_powered_q <= 1'b0;
         wake_q <= 1'b0;
      end else begin
         wake_q <= wake_evt;
         if (wake_evt) begin
            in_sleep_q <= 1'b0;
         end else if (sleep_cmd) begin
            in_sleep_q <= 1'b1;
         end
         if (wake_evt) begin
            down_q <= 1'b0;
         end else if (sleep_abort) begin
            down_q <= 1'b1;
         end else if (sleep_cmd && !rc_sel_q) begin
            down_q <= 1'b1;
         end else if (done_evt && in_sleep_q && !irq_en) begin
            down_q <= 1'b1;
         end
         converter_powered_q <= power_on_q & ~down_q;
      end
   end

   // After wake the next instruction runs first, then service or in-line.
   logic both_en;
   assign both_en = core_q[adc_seq_pkg::CORE_GIE_BIT] & core_q[adc_seq_pkg::CORE_PERIPHERAL_IRQ_ENABLE_BIT];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wake_q_ph <= adc_seq_pkg::WK_NONE;
         exec_next_q <= 1'b0;
         isr_branch_q <= 1'b0;
         resume_inline_q <= 1'b0;
      end else begin
         exec_next_q <= 1'b0;
         isr_branch_q <= 1'b0;
         resume_inline_q <= 1'b0;
         case (wake_q_ph)
            adc_seq_pkg::WK_NONE: begin
               if (wake_evt) begin
                  wake_q_ph <= adc_seq_pkg::WK_NEXT;
               end
            end
            adc_seq_pkg::WK_NEXT: begin
               if (instr_tick) begin
                  exec_next_q <= 1'b1;
                  wake_q_ph <= adc_seq_pkg::WK_DECIDE;
               end
            end
            adc_seq_pkg::WK_DECIDE: begin
               if (instr_tick) begin
                  isr_branch_q <= both_en;
                  resume_inline_q <= ~both_en;
                  wake_q_ph <= adc_seq_pkg::WK_NONE;
               end
            end
            default: begin
               wake_q_ph <= adc_seq_pkg::WK_NONE;
            end
         endcase
      end
   end

   // The trigger always clears the secondary counter, even when unpowered.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         counter_reset_q <= 1'b0;
      end else begin
         counter_reset_q <= special_trigger;
      end
   end

   // Checks on the sequencer.
   a_busy_needs_power: assert property (@(posedge clk) disable iff (rst) busy |-> power_on_q)
      else $error("busy without power");
   a_write_starts: assert property (@(posedge clk) disable iff (rst)
      (sw_start && !busy && !down_q && !hw_start) |=> busy)
      else $error("start write ignored");
   a_done_loads: assert property (@(posedge clk) disable iff (rst)
      done_evt |=> (!busy && flags_q[0] && result_q == $past(sar_resolved)))
      else $error("completion effects missing");
   a_flag_unmasked: assert property (@(posedge clk) disable iff (rst)
      (done_evt && !irq_en && !enables_wr) |=> flags_q[0] ##1 !irq_q)
      else $error("flag or masking wrong");
   a_partial_fill: assert property (@(posedge clk) disable iff (rst)
      partial_evt |=> (result_q == $past(partial) && !busy))
      else $error("partial result wrong");
   a_rc_delay: assert property (@(posedge clk) disable iff (rst)
      (start && rc_sel_q) |=> state_q == adc_seq_pkg::ST_DELAY)
      else $error("rc start not delayed");
   a_sleep_wake: assert property (@(posedge clk) disable iff (rst)
      (done_evt && in_sleep_q && irq_en) |=> (wake_q && !in_sleep_q))
      else $error("no wake on completion");
   a_sleep_down: assert property (@(posedge clk) disable iff (rst)
      (done_evt && in_sleep_q && !irq_en && !other_wake && !ctrl_wr) |=> (down_q && power_on_q) ##1 !converter_powered_q)
      else $error("no power down after sleep completion");
   a_sleep_abort: assert property (@(posedge clk) disable iff (rst)
      (sleep_abort && !ctrl_wr && !in_sleep_q) |=> (!busy && down_q && power_on_q))
      else $error("sleep did not abort");
   a_branch_order: assert property (@(posedge clk) disable iff (rst)
      isr_branch_q |-> $past(exec_next_q, 4))
      else $error("service before next instruction");
   a_trigger_reset: assert property (@(posedge clk) disable iff (rst)
      special_trigger |=> counter_reset_q)
      else $error("counter not reset");
   a_last_step: assert property (@(posedge clk) disable iff (rst) done_evt |-> step_q == 3'h0)
      else $error("completion before last bit");
endmodule
`default_nettype wire

// [test/comp_model.sv]
// Behavioural comparator standing on the analog side of the sequencer.
// Assumes the trial code and the analog power enable come from the design.
`default_nettype none
module comp_model (
   // Clock.
   input wire logic clk,
   // Analog side.
   input wire logic [7:0] sar_code,
   input wire logic [7:0] vin,
   input wire logic powered,
   output logic comp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic junk_q = 1'b0;

   // An unpowered comparator gives no valid answer, so it toggles every cycle.
   always_ff @(posedge clk) begin
      junk_q <= ~junk_q;
   end

   // Keep the trial bit while the input is at or above the trial code.
   assign comp = powered ? (vin >= sar_code) : junk_q;
endmodule
`default_nettype wire

// [test/adc_conversion_sequencer_tb_top.sv]
// Self-checking bench for the conversion sequencer over its register port.
// Assumes the comparator model and the design package are compiled first.
`default_nettype none
module adc_conversion_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic special_trigger = 1'b0;
   logic sleep_cmd = 1'b0;
   logic other_wake = 1'b0;
   logic [7:0] vin = 8'hA5;
   logic comp_in;
   logic [7:0] rdata_q;
   logic [7:0] sar_code_q;
   logic converter_powered_q, counter_reset_q, in_sleep_q, wake_q;
   logic exec_next_q, isr_branch_q, resume_inline_q, irq_q;
   int fail_count = 0;
   int checked = 0;
   int n;

   // Clock at 25 MHz.
   always #20 clk = ~clk;

   adc_conversion_sequencer DUT (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_q(rdata_q), .comp_in(comp_in), .sar_code_q(sar_code_q), .converter_powered_q(converter_powered_q),
      .special_trigger(special_trigger), .counter_reset_q(counter_reset_q), .sleep_cmd(sleep_cmd),
      .other_wake(other_wake), .in_sleep_q(in_sleep_q), .wake_q(wake_q), .exec_next_q(exec_next_q),
      .isr_branch_q(isr_branch_q), .resume_inline_q(resume_inline_q), .irq_q(irq_q));

   comp_model analog (.clk(clk), .sar_code(sar_code_q), .vin(vin), .powered(converter_powered_q), .comp(comp_in));

   // Comparison helper; values are eight bits so flags are zero-extended.
   task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
      end
   endtask

   // One-cycle write strobe beside address and data.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string m);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata_q, e, m);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic pulse_sleep;
      @(posedge clk) sleep_cmd <= 1'b1;
      @(posedge clk) sleep_cmd <= 1'b0;
   endtask

   task automatic pulse_wake;
      @(posedge clk) other_wake <= 1'b1;
      @(posedge clk) other_wake <= 1'b0;
   endtask

   // Wake sequence: the next instruction first, then service or in-line.
   task automatic wake_seq(input logic isr);
      for (n = 0; n < 12 && exec_next_q !== 1'b1; n++) cyc(1);
      chk({7'h00, exec_next_q}, 8'h01, "next instruction");
      for (n = 0; n < 12 && isr_branch_q !== 1'b1 && resume_inline_q !== 1'b1; n++) cyc(1);
      chk({6'h00, isr_branch_q, resume_inline_q}, {6'h00, isr, ~isr}, "wake branch");
   endtask

   // Single closing point of the run.
   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Watchdog far beyond the roughly 1400 cycles the sequence needs.
   initial begin
      #400000;
      fail_count++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      stop_test();
   end

   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h00, "ctrl reset");
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'h00, "result reset");
      rd_chk(4'hF, 8'h00, "unmapped read");
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h02);
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h00, "go without power");
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h01);
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h03);
      cyc(0);
      chk(sar_code_q, 8'h80, "first trial msb");
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h03, "busy reads high");
      cyc(90);
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'hA5, "result");
      rd_chk(adc_seq_pkg::FLAGS_OFS, 8'h01, "done flag");
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h01, "busy cleared");
      chk({7'h00, irq_q}, 8'h00, "irq masked");
      wr_reg(adc_seq_pkg::ENABLES_OFS, 8'h01);
      cyc(2);
      chk({7'h00, irq_q}, 8'h01, "irq unmasked");
      cyc(40);
      rd_chk(adc_seq_pkg::FLAGS_OFS, 8'h01, "flag sticky");
      wr_reg(adc_seq_pkg::FLAGS_OFS, 8'h01);
      cyc(2);
      chk({7'h00, irq_q}, 8'h00, "irq cleared");
      // Early stop after three resolved bits 101: the last one, a one, fills below.
      vin = 8'hBF;
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h03);
      cyc(28);
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h01);
      cyc(2);
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'hBF, "partial fill");
      rd_chk(adc_seq_pkg::FLAGS_OFS, 8'h00, "no flag on stop");
      vin = 8'h3C;
      // The trigger comes only while idle, so every conversion gets its full time.
      @(posedge clk) special_trigger <= 1'b1;
      @(posedge clk) special_trigger <= 1'b0;
      #1;
      chk({7'h00, counter_reset_q}, 8'h01, "counter reset");
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h03, "trigger start");
      cyc(90);
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'h3C, "trigger result");
      wr_reg(adc_seq_pkg::FLAGS_OFS, 8'h01);
      // Sleep on the system clock aborts and powers down.
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h03);
      pulse_sleep();
      cyc(3);
      chk({6'h00, converter_powered_q, in_sleep_q}, 8'h01, "sleep abort");
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h01, "power bit stays");
      cyc(90);
      rd_chk(adc_seq_pkg::FLAGS_OFS, 8'h00, "aborted no flag");
      pulse_wake();
      wake_seq(1'b0);
      // RC clock: start is delayed, conversion survives sleep and wakes.
      vin = 8'h5A;
      wr_reg(adc_seq_pkg::CORE_OFS, 8'h03);
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h05);
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h07);
      cyc(0);
      chk({7'h00, DUT.state_q == adc_seq_pkg::ST_DELAY}, 8'h01, "rc start delayed");
      pulse_sleep();
      cyc(3);
      chk({7'h00, converter_powered_q}, 8'h01, "rc runs in sleep");
      for (n = 0; n < 700 && wake_q !== 1'b1; n++) cyc(1);
      chk({7'h00, wake_q}, 8'h01, "irq wake");
      wake_seq(1'b1);
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'h5A, "rc result");
      wr_reg(adc_seq_pkg::FLAGS_OFS, 8'h01);
      // RC clock without interrupt: powers down after completion.
      vin = 8'h81;
      wr_reg(adc_seq_pkg::ENABLES_OFS, 8'h00);
      wr_reg(adc_seq_pkg::CTRL_OFS, 8'h07);
      pulse_sleep();
      cyc(500);
      chk({6'h00, converter_powered_q, in_sleep_q}, 8'h01, "rc power down");
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h05, "power bit stays");
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'h81, "sleep result");
      rd_chk(adc_seq_pkg::FLAGS_OFS, 8'h01, "flag unmasked off");
      pulse_wake();
      cyc(12);
      // Mid-run reset returns every register to zero.
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(adc_seq_pkg::CTRL_OFS, 8'h00, "ctrl after reset");
      rd_chk(adc_seq_pkg::RESULT_OFS, 8'h00, "result after reset");
      rd_chk(adc_seq_pkg::CORE_OFS, 8'h00, "core after reset");
      stop_test();
   end
endmodule
`default_nettype wire
